// File: common/status_reg_pkg.sv
package status_reg_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register offsets.
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          STRB_W        = 4;
    localparam logic [7:0]  STATUS_OFFSET = 8'h00;
    localparam logic [7:0]  ENABLE_OFFSET = 8'h04;
    localparam logic [7:0]  CLEAR_OFFSET  = 8'h08;

    // ------------------------------------------------------------------
    // Field positions inside the status register.
    // ------------------------------------------------------------------
    localparam int TX_DONE_BIT          = 0;
    localparam int TX_HALTED_BIT        = 1;
    localparam int TX_NO_DESCRIPTOR_BIT = 2;
    localparam int TX_UNDERFLOW_BIT     = 5;
    localparam int RX_DONE_BIT          = 6;
    localparam int RX_NO_BUFFER_BIT     = 7;
    localparam int RX_HALTED_BIT        = 8;
    localparam int EARLY_TX_BIT         = 10;
    localparam int TIMER_EXPIRED_BIT    = 11;
    localparam int EARLY_RECEIVE_BIT    = 14;
    localparam int ABNORMAL_SUMMARY_BIT = 15;
    localparam int NORMAL_SUMMARY_BIT   = 16;
    localparam int RX_STATE_LSB         = 17;
    localparam int TX_STATE_LSB         = 20;
    localparam int STATE_W              = 3;

    // ------------------------------------------------------------------
    // Bit groups and values after reset.
    // ------------------------------------------------------------------
    localparam logic [31:0] NORMAL_MASK       = 32'h0000_4845;
    localparam logic [31:0] ABNORMAL_MASK     = 32'h0000_05a2;
    localparam logic [31:0] EVENT_MASK        = 32'h0000_4de7;
    localparam logic [31:0] SUMMARY_MASK      = 32'h0001_8000;
    localparam logic [31:0] FLAG_MASK         = 32'h0001_cde7;
    localparam logic [31:0] STATE_MASK        = 32'h007e_0000;
    localparam logic [31:0] UNUSED_READ_VALUE = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RESET       = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET      = 32'h0000_0000;
    localparam logic [31:0] READ_DATA_RESET   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Process state codes.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_STOPPED   = 3'h0,
        TX_FETCH     = 3'h1,
        TX_WAIT_END  = 3'h2,
        TX_READ_BUF  = 3'h3,
        TX_RESERVED  = 3'h4,
        TX_SETUP     = 3'h5,
        TX_SUSPENDED = 3'h6,
        TX_CLOSE     = 3'h7
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_STOPPED   = 3'h0,
        RX_FETCH     = 3'h1,
        RX_WAIT_END  = 3'h2,
        RX_WAIT_PKT  = 3'h3,
        RX_SUSPENDED = 3'h4,
        RX_CLOSE     = 3'h5,
        RX_RESERVED  = 3'h6,
        RX_WRITE_MEM = 3'h7
    } rx_state_t;

    // ------------------------------------------------------------------
    // Report from the DMA engines, one-cycle event pulses.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic early_receive_event;
        logic timer_expired;
        logic early_tx_event;
        logic rx_halted;
        logic rx_no_buffer;
        logic rx_done;
        logic tx_underflow;
        logic tx_no_descriptor;
        logic tx_halted;
        logic tx_done;
    } dma_events_t;

    typedef struct packed {
        tx_state_t   transmit_state;
        rx_state_t   receive_state;
        dma_events_t events;
    } dma_report_t;

endpackage

// File: src/state_code_filter.sv
`timescale 1ns/10ps

module state_code_filter #(
    parameter logic [2:0] RESERVED_CODE = 3'h4
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] code_in,
    output logic      [2:0] code_q
);

    // Holds the last legal code so that a reserved code is never shown.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_q <= 3'h0;
        end
        else if (code_in != RESERVED_CODE)
        begin
            code_q <= code_in;
        end
    end

endmodule // state_code_filter

// File: src/event_flag_bank.sv
`timescale 1ns/10ps

module event_flag_bank #(
    parameter logic [31:0] IMPL_MASK = 32'h0000_0000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] set_vec,
    input  wire logic [31:0] clear_vec,
    output logic      [31:0] flags_q
);

    // Sticky flags; a set in the same cycle as a clear wins.
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_flag
            if (IMPL_MASK[i])
            begin : g_impl
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                    begin
                        flags_q[i] <= 1'b0;
                    end
                    else if (set_vec[i])
                    begin
                        flags_q[i] <= 1'b1;
                    end
                    else if (clear_vec[i])
                    begin
                        flags_q[i] <= 1'b0;
                    end
                end
            end
            else
            begin : g_none
                assign flags_q[i] = 1'b0;
            end
        end
    endgenerate

endmodule // event_flag_bank

// File: src/status_register_block.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps

// What this block does
// - Unused bits read fixed value, writes ignored.
// - Transmit state is read-only bits 22:20.
// - Transmit state reads 000 when stopped.
// - Running transmit states show their codes.
// - Transmit suspended reads 110; 100 never shown.
// - Receive state is read-only bits 19:17.
// - Receive state reads 000 when stopped.
// - Running receive states show their codes.
// - Receive suspended reads 100; 110 never shown.
// - Bit 16 ORs unmasked normal event bits.
// - Bit 15 ORs unmasked abnormal event bits.
// - Summary bits clear on write one.
// - Bit 14 early receive, write one clears.
// - Bit 0 set at transmit frame end.
// - Bit 6 set when frame fully received.
// - Bit 5 underflow sets and suspends transmit.
// - Bit 11 set when timer reaches zero.
module status_register_block (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire status_reg_pkg::dma_report_t dma_report,
    output logic                             irq,
    output logic                             tx_suspend
);

    // ------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------

    // Matches a word address against a register offset.
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        reg_hit = (addr[7:2] == offset[7:2]);
    endfunction

    // Expands byte strobes into a bit mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Places the DMA event pulses at their status bit positions.
    function automatic logic [31:0] event_word(input status_reg_pkg::dma_events_t ev);
        event_word = 32'h0000_0000;
        event_word[status_reg_pkg::TX_DONE_BIT]          = ev.tx_done;
        event_word[status_reg_pkg::TX_HALTED_BIT]        = ev.tx_halted;
        event_word[status_reg_pkg::TX_NO_DESCRIPTOR_BIT] = ev.tx_no_descriptor;
        event_word[status_reg_pkg::TX_UNDERFLOW_BIT]     = ev.tx_underflow;
        event_word[status_reg_pkg::RX_DONE_BIT]          = ev.rx_done;
        event_word[status_reg_pkg::RX_NO_BUFFER_BIT]     = ev.rx_no_buffer;
        event_word[status_reg_pkg::RX_HALTED_BIT]        = ev.rx_halted;
        event_word[status_reg_pkg::EARLY_TX_BIT]         = ev.early_tx_event;
        event_word[status_reg_pkg::TIMER_EXPIRED_BIT]    = ev.timer_expired;
        event_word[status_reg_pkg::EARLY_RECEIVE_BIT]    = ev.early_receive_event;
    endfunction

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        irq_q;
    logic        tx_suspend_q;
    logic [31:0] enable_q;
    logic [31:0] flags_q;
    logic [2:0]  tx_code_q;
    logic [2:0]  rx_code_q;
    logic        setup_phase;
    logic        access_done;
    logic        write_done;
    logic        hit_status;
    logic        hit_enable;
    logic        hit_clear;
    logic        hit_any;
    logic        read_setup;
    logic        enable_write;
    logic        flag_clear;
    logic [31:0] write_bits;
    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic [31:0] masked_flags;
    logic        normal_or;
    logic        abnormal_or;
    logic [31:0] status_word;
    logic [31:0] read_word;

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    always_comb
    begin
        setup_phase = psel && !penable;
        access_done = psel && penable && pready_q;
        write_done  = access_done && pwrite;
        hit_status  = reg_hit(paddr, status_reg_pkg::STATUS_OFFSET);
        hit_enable  = reg_hit(paddr, status_reg_pkg::ENABLE_OFFSET);
        hit_clear   = reg_hit(paddr, status_reg_pkg::CLEAR_OFFSET);
        hit_any     = hit_status || hit_enable || hit_clear;
        write_bits  = pwdata & lane_mask(pstrb);
    end

    // ------------------------------------------------------------------
    // Register strobes.
    // ------------------------------------------------------------------
    always_comb
    begin
        read_setup   = setup_phase && !pwrite;
        enable_write = write_done && hit_enable;
        flag_clear   = write_done && (hit_status || hit_clear);
    end

    // ------------------------------------------------------------------
    // Ready and error answer.
    // ------------------------------------------------------------------

    // Ready rises in the first access cycle, so every transfer takes two cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup_phase;
        end
    end

    // Accesses outside the three registers answer with an error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_q <= 1'b0;
        end
        else
        begin
            pslverr_q <= setup_phase && !hit_any;
        end
    end

    // ------------------------------------------------------------------
    // Process state fields.
    // ------------------------------------------------------------------

    // Reserved codes are held off; both fields start at the stopped code.
    state_code_filter #(
        .RESERVED_CODE (status_reg_pkg::TX_RESERVED)
    ) u_tx_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .code_in (dma_report.transmit_state),
        .code_q  (tx_code_q)
    );

    state_code_filter #(
        .RESERVED_CODE (status_reg_pkg::RX_RESERVED)
    ) u_rx_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .code_in (dma_report.receive_state),
        .code_q  (rx_code_q)
    );

    // ------------------------------------------------------------------
    // Interrupt enable register.
    // ------------------------------------------------------------------

    // Only event and summary positions hold an enable.
    // A lane whose strobe is low keeps its old enable bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= status_reg_pkg::ENABLE_RESET;
        end
        else if (enable_write)
        begin
            enable_q <= (enable_q & ~(lane_mask(pstrb) & status_reg_pkg::FLAG_MASK))
                      | (write_bits & status_reg_pkg::FLAG_MASK);
        end
    end

    // ------------------------------------------------------------------
    // Event flags and summaries.
    // ------------------------------------------------------------------
    // A summary bit is set again while any enabled source stays set.
    always_comb
    begin
        masked_flags = flags_q & enable_q;
        normal_or    = |(masked_flags & status_reg_pkg::NORMAL_MASK);
        abnormal_or  = |(masked_flags & status_reg_pkg::ABNORMAL_MASK);
        set_vec      = event_word(dma_report.events);
        set_vec[status_reg_pkg::NORMAL_SUMMARY_BIT]   = normal_or;
        set_vec[status_reg_pkg::ABNORMAL_SUMMARY_BIT] = abnormal_or;
        clear_vec    = 32'h0000_0000;
        if (flag_clear)
        begin
            clear_vec = write_bits & status_reg_pkg::FLAG_MASK;
        end
    end

    // Writing one clears a flag; a new event in that cycle keeps it set.
    event_flag_bank #(
        .IMPL_MASK (status_reg_pkg::FLAG_MASK)
    ) u_flags (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_vec   (set_vec),
        .clear_vec (clear_vec),
        .flags_q   (flags_q)
    );

    // ------------------------------------------------------------------
    // Interrupt output.
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |masked_flags;
        end
    end

    // ------------------------------------------------------------------
    // Transmit suspend request.
    // ------------------------------------------------------------------

    // An underflow asks the transmit engine to suspend for one cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_suspend_q <= 1'b0;
        end
        else
        begin
            tx_suspend_q <= dma_report.events.tx_underflow;
        end
    end

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    always_comb
    begin
        status_word = (flags_q & status_reg_pkg::FLAG_MASK)
                    | (status_reg_pkg::UNUSED_READ_VALUE
                       & ~(status_reg_pkg::FLAG_MASK | status_reg_pkg::STATE_MASK));
        status_word[status_reg_pkg::TX_STATE_LSB +: status_reg_pkg::STATE_W] = tx_code_q;
        status_word[status_reg_pkg::RX_STATE_LSB +: status_reg_pkg::STATE_W] = rx_code_q;
        read_word = 32'h0000_0000;
        if (hit_status)
        begin
            read_word = status_word;
        end
        else if (hit_enable)
        begin
            read_word = enable_q;
        end
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= status_reg_pkg::READ_DATA_RESET;
        end
        else if (read_setup)
        begin
            prdata_q <= read_word;
        end
        else if (access_done)
        begin
            prdata_q <= status_reg_pkg::READ_DATA_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign irq        = irq_q;
    assign tx_suspend = tx_suspend_q;

endmodule // status_register_block

// File: tb/status_register_block_asserts.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Port checks for the status register block.
// ----------------------------------------------------------------------
module status_register_block_asserts (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire status_reg_pkg::dma_report_t dma_report,
    input wire logic                        irq,
    input wire logic                        tx_suspend
);
    wire logic setup       = psel && !penable;
    wire logic status_read = pready && !pwrite && paddr[7:2] == 6'h0;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_error_unmapped: assert property (setup && paddr[7:2] > 6'h2 |=> pslverr && pready)
        else $error("no error on unmapped address");
    a_error_mapped: assert property (setup && paddr[7:2] <= 6'h2 |=> !pslverr)
        else $error("error on mapped address");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_unused_bits: assert property (pready |-> (prdata & 32'hff80_3218) == 32'h0)
        else $error("unused read bits not zero");
    a_tx_reserved: assert property (status_read |-> prdata[22:20] != 3'h4)
        else $error("reserved transmit code shown");
    a_rx_reserved: assert property (status_read |-> prdata[19:17] != 3'h6)
        else $error("reserved receive code shown");
    a_tx_state_read: assert property (status_read && $past(dma_report.transmit_state, 2) != 3'h4
        |-> prdata[22:20] == $past(dma_report.transmit_state, 2))
        else $error("transmit state read wrong");
    a_rx_state_read: assert property (status_read && $past(dma_report.receive_state, 2) != 3'h6
        |-> prdata[19:17] == $past(dma_report.receive_state, 2))
        else $error("receive state read wrong");
    a_suspend_follows: assert property (dma_report.events.tx_underflow |=> tx_suspend)
        else $error("no suspend after underflow");
    a_suspend_cause: assert property (tx_suspend |-> $past(dma_report.events.tx_underflow))
        else $error("suspend without underflow");

    c_unmapped: cover property (pready && pslverr);
    c_suspend: cover property (tx_suspend);
    c_irq: cover property (irq);
    c_summary: cover property (status_read && prdata[16]);
endmodule // status_register_block_asserts

// File: tb/test_status_register_block.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Bench with a reference model of the status register.
// ----------------------------------------------------------------------
module test_status_register_block;
    logic                        pclk;
    logic                        presetn;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata;
    logic [3:0]                  pstrb;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    status_reg_pkg::dma_report_t dma_report;
    logic                        irq;
    logic                        tx_suspend;
    int unsigned                 errors;
    int unsigned                 num_checks;
    bit                          rnd;
    int unsigned                 mf, me, mt, mr, mrd, ev, lm, sn, sa;
    bit                          mrdy, merr, mirq, mts;
    int                          pos [10] = '{0, 1, 2, 5, 6, 7, 8, 10, 11, 14};
    logic [31:0]                 en_val [3] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0};
    logic [3:0]                  en_strb [3] = '{4'hf, 4'h2, 4'hf};

    status_register_block dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dma_report(dma_report), .irq(irq), .tx_suspend(tx_suspend)
    );

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Reference model, compared at every clock edge.
    // ------------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (!presetn)
        begin
            {mf, me, mt, mr, mrd} = '0;
            {mrdy, merr, mirq, mts} = '0;
        end
        else
        begin
            check("pready", 32'(pready), 32'(mrdy));
            check("pslverr", 32'(pslverr), 32'(merr));
            check("prdata", prdata, mrd);
            check("irq", 32'(irq), 32'(mirq));
            check("tx_suspend", 32'(tx_suspend), 32'(mts));
            ev = 0;
            for (int i = 0; i < 10; i++)
                if (dma_report.events[i])
                    ev = ev | (1 << pos[i]);
            sn = ((mf & me & status_reg_pkg::NORMAL_MASK) != 0) ? 32'h0001_0000 : 0;
            sa = ((mf & me & status_reg_pkg::ABNORMAL_MASK) != 0) ? 32'h0000_8000 : 0;
            lm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
            mirq = (mf & me) != 0;
            mts = dma_report.events.tx_underflow;
            mrd = 0;
            merr = 1'b0;
            mrdy = psel && !penable;
            if (mrdy)
            begin
                merr = paddr[7:2] > 6'h2;
                if (!pwrite && paddr[7:2] == 6'h0)
                    mrd = mf | (mt << 20) | (mr << 17);
                if (!pwrite && paddr[7:2] == 6'h1)
                    mrd = me;
            end
            if (psel && penable && pready && pwrite)
            begin
                if (paddr[7:2] == 6'h0 || paddr[7:2] == 6'h2)
                    mf = mf & ~(pwdata & lm & status_reg_pkg::FLAG_MASK);
                if (paddr[7:2] == 6'h1)
                    me = (me & ~lm) | (pwdata & lm & status_reg_pkg::FLAG_MASK);
            end
            mf = mf | ev | sn | sa;
            if (dma_report.transmit_state != 3'h4)
                mt = dma_report.transmit_state;
            if (dma_report.receive_state != 3'h6)
                mr = dma_report.receive_state;
        end
    end

    always @(posedge pclk)
        if (rnd)
            dma_report <= status_reg_pkg::dma_report_t'({3'($urandom), 3'($urandom),
                10'($urandom & $urandom & $urandom)});

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial
    begin
        {errors, num_checks, rnd} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        dma_report = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(14908));
        for (int a = 0; a < 5; a++)
            apb(1'b0, 8'(a * 4), 32'h0, 4'h0);
        apb(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
        apb(1'b1, 8'h10, 32'hffff_ffff, 4'hf);
        for (int c = 0; c < 8; c++)
        begin
            dma_report.transmit_state <= status_reg_pkg::tx_state_t'(c);
            dma_report.receive_state  <= status_reg_pkg::rx_state_t'(7 - c);
            apb(1'b0, 8'h00, 32'h0, 4'h0);
        end
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, 8'h04, 32'h0, 4'hf);
            apb(1'b1, 8'h04, en_val[m], en_strb[m]);
            apb(1'b0, 8'h04, 32'h0, 4'h0);
            for (int b = 0; b < 10; b++)
            begin
                @(posedge pclk);
                dma_report.events <= status_reg_pkg::dma_events_t'(10'h1 << b);
                @(posedge pclk);
                dma_report.events <= '0;
                apb(1'b0, 8'h00, 32'h0, 4'h0);
                apb(1'b1, 8'h00, 32'h0, 4'hf);
                apb(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
                apb(1'b0, 8'h00, 32'h0, 4'h0);
                apb(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
                apb(1'b0, 8'h08, 32'h0, 4'h0);
            end
        end
        rnd = 1'b1;
        repeat (400)
            apb(1'($urandom), 8'($urandom_range(0, 4) * 4), $urandom, 4'($urandom));
        rnd = 1'b0;
        repeat (3) @(posedge pclk);
        end_of_test();
    end
endmodule // test_status_register_block

bind status_register_block status_register_block_asserts chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_report(dma_report), .irq(irq), .tx_suspend(tx_suspend)
);
